//--- spseq_map.svh
// Constant map of the self-polling run sequencer.
`ifndef SPSEQ_MAP_SVH
`define SPSEQ_MAP_SVH
`define SPSEQ_NUM_CFG 4
`define SPSEQ_MAX_CHAN 3
`define SPSEQ_TO_WIDTH 16
`define SPSEQ_CFG_A 2'h0
`define SPSEQ_CHAN_FIRST 2'h1
`define SPSEQ_NEXT_CHAN 2'h0
`define SPSEQ_NEXT_CFG 2'h1
`define SPSEQ_RESTART_A 2'h2
`define SPSEQ_RELOAD 2'h3
`define SPSEQ_POLL_COO 2'h0
`define SPSEQ_FIFO_CYCLE 1'b0
`define SPSEQ_FIFO_FRAME 1'b1
`define SPSEQ_MOD_WAKE 1'b0
`define SPSEQ_MOD_RUN 1'b1
`endif

//--- spseq_pkg.sv
// Types of the self-polling run sequencer.
package spseq_pkg;
	typedef enum logic [3:0] {
		SPSEQ_IDLE = 4'b0001,
		SPSEQ_SEARCH = 4'b0010,
		SPSEQ_RUN = 4'b0100,
		SPSEQ_OFF = 4'b1000
	} spseq_state_t;
endpackage

//--- spseq_sync.sv
// Three-flop input synchroniser with agreement of the last two stages.
`timescale 1ns/1ns
`default_nettype none
module spseq_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	if (WIDTH < 1) begin
		$error("spseq_sync: WIDTH must be at least 1.");
	end
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2[i] == s3[i]) begin
					dout[i] <= s3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- spseq_timer.sv
// Loadable down-counter used as a reception timeout.
`timescale 1ns/1ns
`default_nettype none
module spseq_timer #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic run,
	input wire logic [WIDTH-1:0] value,
	output logic expired
);
	if (WIDTH < 2) begin
		$error("spseq_timer: WIDTH must be at least 2.");
	end
	logic [WIDTH-1:0] count;
	logic armed;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			armed <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (load) begin
				count <= value;
				armed <= (value != '0);
			end else if (run && armed) begin
				if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
					armed <= 1'b0;
					expired <= 1'b1;
				end
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

//--- spseq_top.sv
// Self-polling run sequencer: wake-up search, post-wake run state and exits.
`timescale 1ns/1ns
`default_nettype none
`include "spseq_map.svh"
module spseq_top import spseq_pkg::*; #(
	parameter int NUM_CFG = `SPSEQ_NUM_CFG,
	parameter int TO_WIDTH = `SPSEQ_TO_WIDTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic master_mode_select,
	input wire logic sleepReq,
	input wire logic [1:0] pollMode,
	input wire logic [NUM_CFG-1:0] cfgEnable,
	input wire logic [NUM_CFG*2-1:0] config_channel_setup,
	input wire logic [NUM_CFG-1:0] external_processing_field,
	input wire logic [NUM_CFG*TO_WIDTH-1:0] sync_loss_timeout,
	input wire logic [NUM_CFG*TO_WIDTH-1:0] no_sync_word_timeout,
	input wire logic [NUM_CFG*TO_WIDTH-1:0] no_end_timeout,
	input wire logic modulation_type_select,
	input wire logic modSwitchEn,
	input wire logic msgIdScanEn,
	input wire logic fifoInitMode,
	input wire logic fifoLocked,
	input wire logic return_after_end_bit,
	input wire logic [1:0] endAction,
	input wire logic [1:0] timeoutAction,
	input wire logic parallel_wake_enable,
	input wire logic shared_pattern_bits_option,
	input wire logic [2:0] irqMask,
	input wire logic wakeFound,
	input wire logic onTimeDone,
	input wire logic offTimeDone,
	input wire logic symbolSync,
	input wire logic frame_sync_word,
	input wire logic msgIdFound,
	input wire logic end_of_message,
	input wire logic external_timeout_command,
	input wire logic external_end_command,
	output logic [3:0] stateOut,
	output logic [1:0] activeCfg,
	output logic [1:0] activeChan,
	output logic demodType,
	output logic [1:0] wake_channel_record,
	output logic [3:0] payloadRecord,
	output logic fifoClear,
	output logic fifoWriteEn,
	output logic idScanActive,
	output logic syncSearch,
	output logic syncRegReset,
	output logic pollTimerInit,
	output logic parallelWakeActive,
	output logic irqFrameStart,
	output logic irqMsgId,
	output logic irqEnd
);
	// The configuration index is two bits wide, so at most four sets fit.
	if (NUM_CFG < 1 || NUM_CFG > 4 || TO_WIDTH < 2) begin
		$error("spseq_top: unsupported parameter values.");
	end

	// Symbol sync and the sleep request are synchronised; one-cycle strobes from on-chip logic are not.
	logic [1:0] pinSync;
	logic symSync;
	logic sleepSync;
	spseq_sync #(.WIDTH(2)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.din({symbolSync, sleepReq}),
		.dout(pinSync)
	);
	assign symSync = pinSync[1];
	assign sleepSync = pinSync[0];

	function automatic logic [1:0] chanCount(input logic [NUM_CFG*2-1:0] setup,
		input logic [1:0] cfg);
		logic [1:0] n;
		n = setup[cfg*2 +: 2];
		chanCount = (n == 2'h0) ? 2'h1 : n;
	endfunction

	function automatic logic [TO_WIDTH-1:0] pick(input logic [NUM_CFG*TO_WIDTH-1:0] v,
		input logic [1:0] cfg);
		pick = v[cfg*TO_WIDTH +: TO_WIDTH];
	endfunction

	spseq_state_t state;
	logic inRun;
	logic payloadSeen;
	logic pwuEnded;
	logic inPayload;
	logic syncLost;
	logic extAllowed;
	logic extTimeout;
	logic extEnd;
	logic toSync;
	logic toWord;
	logic toEnd;
	logic anyTimeout;
	logic endEvent;
	logic runEntry;
	logic reloadTimers;
	logic lastCfg;
	logic lastChan;
	logic [1:0] nextCfgIdx;
	logic nextCfgFound;

	assign inRun = (state == SPSEQ_RUN);
	assign extAllowed = external_processing_field[activeCfg];
	assign extTimeout = inRun && extAllowed && external_timeout_command;
	assign extEnd = inRun && extAllowed && external_end_command;
	assign endEvent = inRun && (end_of_message || extEnd);
	assign anyTimeout = inRun && (toSync || toWord || toEnd || extTimeout);
	assign runEntry = (state == SPSEQ_SEARCH) && wakeFound;
	assign lastChan = (activeChan >= chanCount(config_channel_setup, activeCfg));

	always_comb begin
		nextCfgIdx = `SPSEQ_CFG_A;
		nextCfgFound = 1'b0;
		for (int i = NUM_CFG - 1; i >= 0; i--) begin
			if (i > activeCfg && cfgEnable[i]) begin
				nextCfgIdx = 2'(i);
				nextCfgFound = 1'b1;
			end
		end
	end
	assign lastCfg = !nextCfgFound;

	// Timers are loaded on entry and on reload after end; external end reloads as well.
	assign reloadTimers = runEntry || (endEvent && endAction == `SPSEQ_RELOAD
		&& !return_after_end_bit) || extEnd;

	spseq_timer #(.WIDTH(TO_WIDTH)) u_toSync (
		.clk(clk),
		.rst_b(rst_b),
		.load(reloadTimers || (inRun && !syncLost)),
		.run(inRun && syncLost),
		.value(pick(sync_loss_timeout, activeCfg)),
		.expired(toSync)
	);
	spseq_timer #(.WIDTH(TO_WIDTH)) u_toWord (
		.clk(clk),
		.rst_b(rst_b),
		.load(reloadTimers || (inRun && frame_sync_word)),
		.run(inRun && !inPayload),
		.value(pick(no_sync_word_timeout, activeCfg)),
		.expired(toWord)
	);
	spseq_timer #(.WIDTH(TO_WIDTH)) u_toEnd (
		.clk(clk),
		.rst_b(rst_b),
		.load(reloadTimers),
		.run(inRun),
		.value(pick(no_end_timeout, activeCfg)),
		.expired(toEnd)
	);

	// Main sequencing between search, run and off.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SPSEQ_IDLE;
			activeCfg <= `SPSEQ_CFG_A;
			activeChan <= `SPSEQ_CHAN_FIRST;
			pollTimerInit <= 1'b0;
		end else begin
			pollTimerInit <= 1'b0;
			case (state)
				SPSEQ_IDLE: begin
					if (master_mode_select && !sleepSync) begin
						state <= SPSEQ_SEARCH;
						activeCfg <= `SPSEQ_CFG_A;
						activeChan <= `SPSEQ_CHAN_FIRST;
						pollTimerInit <= 1'b1;
					end
				end
				SPSEQ_SEARCH: begin
					if (!master_mode_select || sleepSync) begin
						state <= SPSEQ_IDLE;
					end else if (wakeFound) begin
						state <= SPSEQ_RUN;
					end else if (onTimeDone) begin
						if (!lastChan) begin
							activeChan <= activeChan + 2'h1;
						end else if (!lastCfg) begin
							activeCfg <= nextCfgIdx;
							activeChan <= `SPSEQ_CHAN_FIRST;
						end else begin
							state <= SPSEQ_OFF;
						end
					end
				end
				SPSEQ_RUN: begin
					if (!master_mode_select || sleepSync) begin
						state <= SPSEQ_IDLE;
					end else if (anyTimeout) begin
						// Constant on-off always restarts the poll period.
						pollTimerInit <= (timeoutAction == `SPSEQ_RESTART_A)
							|| (pollMode == `SPSEQ_POLL_COO);
						state <= SPSEQ_SEARCH;
						if (timeoutAction == `SPSEQ_RESTART_A) begin
							activeCfg <= `SPSEQ_CFG_A;
							activeChan <= `SPSEQ_CHAN_FIRST;
						end else if (!lastChan) begin
							activeChan <= activeChan + 2'h1;
						end else if (!lastCfg) begin
							activeCfg <= nextCfgIdx;
							activeChan <= `SPSEQ_CHAN_FIRST;
						end else begin
							state <= SPSEQ_OFF;
						end
					end else if (endEvent && (return_after_end_bit
						|| endAction != `SPSEQ_RELOAD)) begin
						pollTimerInit <= (endAction == `SPSEQ_RESTART_A)
							|| (pollMode == `SPSEQ_POLL_COO);
						state <= SPSEQ_SEARCH;
						if (endAction == `SPSEQ_RESTART_A) begin
							activeCfg <= `SPSEQ_CFG_A;
							activeChan <= `SPSEQ_CHAN_FIRST;
						end else if (!lastCfg) begin
							activeCfg <= nextCfgIdx;
							activeChan <= `SPSEQ_CHAN_FIRST;
						end else begin
							state <= SPSEQ_OFF;
						end
					end
				end
				SPSEQ_OFF: begin
					if (!master_mode_select || sleepSync) begin
						state <= SPSEQ_IDLE;
					end else if (offTimeDone) begin
						state <= SPSEQ_SEARCH;
						activeCfg <= `SPSEQ_CFG_A;
						activeChan <= `SPSEQ_CHAN_FIRST;
						pollTimerInit <= 1'b1;
					end
				end
				default: begin
					state <= SPSEQ_IDLE;
				end
			endcase
		end
	end

	assign stateOut = state;

	// Frame tracking inside the run state.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inPayload <= 1'b0;
			payloadSeen <= 1'b0;
			syncLost <= 1'b0;
			pwuEnded <= 1'b0;
		end else begin
			if (!inRun || runEntry) begin
				inPayload <= 1'b0;
				payloadSeen <= 1'b0;
				syncLost <= 1'b0;
				pwuEnded <= 1'b0;
			end else begin
				syncLost <= !symSync;
				if (frame_sync_word) begin
					inPayload <= 1'b1;
				end else if (endEvent) begin
					inPayload <= 1'b0;
					payloadSeen <= 1'b1;
				end
				// A lost sync or a wake-up ends the parallel search; only an end event or leaving the run state re-arms it.
				if (parallelWakeActive && (!symSync || wakeFound)) begin
					pwuEnded <= 1'b1;
				end else if (endEvent) begin
					pwuEnded <= 1'b0;
				end
			end
		end
	end

	// Datapath controls and records.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			demodType <= `SPSEQ_MOD_WAKE;
			wake_channel_record <= `SPSEQ_CHAN_FIRST;
			payloadRecord <= 4'h0;
			fifoClear <= 1'b0;
			fifoWriteEn <= 1'b0;
			idScanActive <= 1'b0;
			syncSearch <= 1'b0;
			syncRegReset <= 1'b0;
			parallelWakeActive <= 1'b0;
			irqFrameStart <= 1'b0;
			irqMsgId <= 1'b0;
			irqEnd <= 1'b0;
		end else begin
			demodType <= (inRun && modSwitchEn) ? modulation_type_select
				: `SPSEQ_MOD_WAKE;
			if (runEntry) begin
				wake_channel_record <= activeChan;
			end
			if (inRun && end_of_message) begin
				payloadRecord <= {activeCfg, activeChan};
			end
			fifoClear <= (runEntry && fifoInitMode == `SPSEQ_FIFO_CYCLE)
				|| (inRun && frame_sync_word && !fifoLocked
				&& fifoInitMode == `SPSEQ_FIFO_FRAME);
			fifoWriteEn <= inRun && inPayload;
			idScanActive <= inRun && inPayload && msgIdScanEn;
			syncSearch <= inRun && !inPayload;
			// Shared-bit patterns need the framer history that the wake-up already filled.
			syncRegReset <= runEntry && !shared_pattern_bits_option;
			parallelWakeActive <= inRun && parallel_wake_enable && payloadSeen
				&& !inPayload && symSync && !syncLost && !pwuEnded;
			irqFrameStart <= inRun && frame_sync_word && !irqMask[0];
			irqMsgId <= inRun && inPayload && msgIdScanEn && msgIdFound
				&& !irqMask[1];
			irqEnd <= endEvent && !irqMask[2];
		end
	end
endmodule
`default_nettype wire

//--- spseq_top_properties.sv
// Concurrent checks on the ports of the self-polling run sequencer.
`timescale 1ns/1ns
`default_nettype none
module spseq_top_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic master_mode_select,
	input wire logic sleepReq,
	input wire logic wakeFound,
	input wire logic fifoInitMode,
	input wire logic shared_pattern_bits_option,
	input wire logic frame_sync_word,
	input wire logic end_of_message,
	input wire logic return_after_end_bit,
	input wire logic external_timeout_command,
	input wire logic [2:0] irqMask,
	input wire logic [3:0] stateOut,
	input wire logic [1:0] activeChan,
	input wire logic [1:0] wake_channel_record,
	input wire logic fifoClear,
	input wire logic syncRegReset,
	input wire logic pollTimerInit,
	input wire logic irqFrameStart,
	input wire logic irqEnd
);
	logic [3:0] sleepHist;
	logic calm;
	logic wk;
	// Sleep crosses a synchroniser, so recent sleep requests may still win.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sleepHist <= 4'h0;
		end else begin
			sleepHist <= {sleepHist[2:0], sleepReq};
		end
	end
	assign calm = master_mode_select && !sleepReq && sleepHist == 4'h0;
	assign wk = calm && stateOut == 4'h2 && wakeFound;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_search_start: assert property (stateOut == 4'h1 && calm |=> stateOut == 4'h2 && pollTimerInit)
		else $error("search not started");
	chk_wake_run: assert property (wk |=> stateOut == 4'h4)
		else $error("wake did not enter run");
	chk_cycle_clear: assert property (wk && !fifoInitMode |=> fifoClear)
		else $error("no fifo clear on entry");
	chk_sync_reset: assert property (wk |=> syncRegReset == !shared_pattern_bits_option)
		else $error("sync compare reset wrong");
	chk_wake_record: assert property (wk |=> ##1 wake_channel_record == $past(activeChan, 2))
		else $error("wake channel not recorded");
	chk_frame_irq: assert property (stateOut == 4'h4 && frame_sync_word && irqMask == 3'h0 |=> irqFrameStart)
		else $error("frame event missing");
	chk_end_irq: assert property (stateOut == 4'h4 && end_of_message && irqMask == 3'h0 && !external_timeout_command |=> irqEnd)
		else $error("end event missing");
	chk_masked_quiet: assert property (irqMask == 3'h7 |=> !irqFrameStart && !irqEnd)
		else $error("masked event raised");
	chk_end_return: assert property (stateOut == 4'h4 && end_of_message && return_after_end_bit |=> stateOut != 4'h4)
		else $error("run kept after end");
	chk_sleep_idle: assert property (sleepReq [*6] |-> stateOut == 4'h1)
		else $error("sleep did not idle");
endmodule
bind spseq_top spseq_top_chk u_chk (.clk, .rst_b, .master_mode_select, .sleepReq, .wakeFound,
	.fifoInitMode, .shared_pattern_bits_option, .frame_sync_word, .end_of_message,
	.return_after_end_bit, .external_timeout_command, .irqMask, .stateOut, .activeChan,
	.wake_channel_record, .fifoClear, .syncRegReset, .pollTimerInit, .irqFrameStart, .irqEnd);
`default_nettype wire

//--- spseq_host_model.sv
// Host model that ends a stale frame search when symbol sync drops.
`timescale 1ns/1ns
`default_nettype none
module spseq_host_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic symbolSync,
	input wire logic irqFrameStart,
	output logic extEnd
);
	logic syncDly;
	logic heard;
	// One-cycle reaction keeps the command period far below the run-in length.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			syncDly <= 1'b0;
			heard <= 1'b0;
			extEnd <= 1'b0;
		end else begin
			syncDly <= symbolSync;
			heard <= (heard || irqFrameStart) && !(symbolSync && !syncDly);
			extEnd <= enable && syncDly && !symbolSync && !heard;
		end
	end
endmodule
`default_nettype wire

//--- spseq_top_tb_top.sv
// Directed testbench of the self-polling run sequencer.
`timescale 1ns/1ns
`default_nettype none
module spseq_top_tb_top;
	logic clk, rst_b, master_mode_select, sleepReq, modulation_type_select, modSwitchEn;
	logic msgIdScanEn, fifoInitMode, fifoLocked, return_after_end_bit, parallel_wake_enable;
	logic shared_pattern_bits_option, wakeFound, onTimeDone, offTimeDone, symbolSync;
	logic frame_sync_word, msgIdFound, end_of_message, external_timeout_command, extEndTb;
	logic [1:0] pollMode, endAction, timeoutAction, activeCfg, activeChan, wake_channel_record;
	logic [3:0] cfgEnable, external_processing_field, stateOut, payloadRecord;
	logic [7:0] config_channel_setup;
	logic [31:0] sync_loss_timeout, no_sync_word_timeout, no_end_timeout;
	logic [2:0] irqMask;
	logic demodType, fifoClear, fifoWriteEn, idScanActive, syncSearch, syncRegReset, extEndHost;
	logic pollTimerInit, parallelWakeActive, irqFrameStart, irqMsgId, irqEnd, initSeen, hostEn;
	int num_errors, compares;
	spseq_top #(.TO_WIDTH(8)) u_dut (.clk, .rst_b, .master_mode_select, .sleepReq, .pollMode,
		.cfgEnable, .config_channel_setup, .external_processing_field, .sync_loss_timeout,
		.no_sync_word_timeout, .no_end_timeout, .modulation_type_select, .modSwitchEn,
		.msgIdScanEn, .fifoInitMode, .fifoLocked, .return_after_end_bit, .endAction,
		.timeoutAction, .parallel_wake_enable, .shared_pattern_bits_option, .irqMask, .wakeFound,
		.onTimeDone, .offTimeDone, .symbolSync, .frame_sync_word, .msgIdFound, .end_of_message,
		.external_timeout_command, .external_end_command(extEndTb | extEndHost), .stateOut,
		.activeCfg, .activeChan, .demodType, .wake_channel_record, .payloadRecord, .fifoClear,
		.fifoWriteEn, .idScanActive, .syncSearch, .syncRegReset, .pollTimerInit,
		.parallelWakeActive, .irqFrameStart, .irqMsgId, .irqEnd);
	spseq_host_model u_host (.clk, .rst_b, .enable(hostEn), .symbolSync, .irqFrameStart,
		.extEnd(extEndHost));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (pollTimerInit === 1'b1) initSeen = 1'b1;
	task automatic end_sim();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic waitSt(input logic [3:0] st);
		int i;
		for (i = 0; i < 300 && stateOut !== st; i++) tick(1);
		if (stateOut !== st) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic wakeUp();
		waitSt(4'h2);
		wakeFound = 1'b1;
		tick(1);
		wakeFound = 1'b0;
		waitSt(4'h4);
		initSeen = 1'b0;
	endtask
	task automatic extCmd(input logic isEnd);
		external_timeout_command = !isEnd;
		extEndTb = isEnd;
		tick(1);
		external_timeout_command = 1'b0;
		extEndTb = 1'b0;
	endtask
	initial begin
		{master_mode_select, sleepReq, modSwitchEn, msgIdScanEn, fifoInitMode, fifoLocked} = '0;
		{return_after_end_bit, parallel_wake_enable, shared_pattern_bits_option, wakeFound} = '0;
		{onTimeDone, offTimeDone, symbolSync, frame_sync_word, msgIdFound, end_of_message} = '0;
		{external_timeout_command, extEndTb, hostEn, pollMode, endAction, timeoutAction} = '0;
		{sync_loss_timeout, no_end_timeout, irqMask, external_processing_field} = '0;
		num_errors = 0;
		compares = 0;
		initSeen = 1'b0;
		rst_b = 1'b0;
		cfgEnable = 4'hf;
		config_channel_setup = 8'h57;
		no_sync_word_timeout = {4{8'h14}};
		modulation_type_select = 1'b1;
		pollMode = 2'h1;
		tick(12);
		rst_b = 1'b1;
		tick(1);
		chk(stateOut, 8'h1);
		chk(wake_channel_record, 8'h1);
		$display("reset test done");
		{master_mode_select, modSwitchEn, msgIdScanEn, return_after_end_bit} = '1;
		wakeUp();
		tick(2);
		chk(demodType, 8'h1);
		chk(syncSearch, 8'h1);
		frame_sync_word = 1'b1;
		tick(1);
		frame_sync_word = 1'b0;
		msgIdFound = 1'b1;
		tick(1);
		msgIdFound = 1'b0;
		chk(irqMsgId, 8'h1);
		chk(idScanActive, 8'h1);
		chk(fifoWriteEn, 8'h1);
		chk(syncSearch, 8'h0);
		endAction = 2'h1;
		end_of_message = 1'b1;
		tick(1);
		end_of_message = 1'b0;
		waitSt(4'h2);
		tick(1);
		chk(payloadRecord, 8'h1);
		chk(activeCfg, 8'h1);
		chk(initSeen, 8'h0);
		$display("payload test done");
		timeoutAction = 2'h2;
		wakeUp();
		tick(10);
		chk(stateOut, 8'h4);
		waitSt(4'h2);
		tick(1);
		chk(activeCfg, 8'h0);
		chk(initSeen, 8'h1);
		timeoutAction = 2'h0;
		wakeUp();
		waitSt(4'h2);
		tick(1);
		chk(activeChan, 8'h2);
		chk(initSeen, 8'h0);
		pollMode = 2'h0;
		wakeUp();
		waitSt(4'h2);
		tick(1);
		chk(activeChan, 8'h3);
		chk(initSeen, 8'h1);
		$display("timeout test done");
		{external_processing_field, timeoutAction} = {4'hf, 2'h1};
		wakeUp();
		extCmd(1'b0);
		waitSt(4'h2);
		chk(activeCfg, 8'h1);
		{external_processing_field, endAction, return_after_end_bit} = '0;
		wakeUp();
		extCmd(1'b0);
		tick(3);
		chk(stateOut, 8'h4);
		external_processing_field = 4'hf;
		endAction = 2'h3;
		tick(10);
		extCmd(1'b1);
		tick(14);
		chk(stateOut, 8'h4);
		$display("command test done");
		{parallel_wake_enable, hostEn, irqMask} = {2'h3, 3'h7};
		fifoInitMode = 1'b1;
		frame_sync_word = 1'b1;
		tick(1);
		frame_sync_word = 1'b0;
		chk(fifoClear, 8'h1);
		end_of_message = 1'b1;
		tick(1);
		end_of_message = 1'b0;
		symbolSync = 1'b1;
		tick(8);
		chk(parallelWakeActive, 8'h1);
		symbolSync = 1'b0;
		tick(8);
		chk(parallelWakeActive, 8'h0);
		chk(stateOut, 8'h4);
		symbolSync = 1'b1;
		tick(8);
		chk(parallelWakeActive, 8'h0);
		$display("parallel test done");
		{irqMask, hostEn, parallel_wake_enable, fifoInitMode, symbolSync} = '0;
		extCmd(1'b0);
		repeat (1) begin
			wakeUp();
			extCmd(1'b0);
		end
		endAction = 2'h1;
		wakeUp();
		extCmd(1'b1);
		waitSt(4'h8);
		chk(stateOut, 8'h8);
		sleepReq = 1'b1;
		tick(8);
		chk(stateOut, 8'h1);
		$display("off and sleep test done");
		end_sim();
	end
endmodule
`default_nettype wire
